// >>> src/charge_current_voltage_regs.sv
// serial slave and register bank for charge current and voltage settings
`timescale 1ns/1ns
`default_nettype none
`include "charge_regs_cfg.svh"

// Overview of operation
// - six-bit fast charge code, 512 mA plus 64 mA steps
// - charge current register resets to 0x20
// - cold select bit picks 76% or 79% threshold
// - force bit gives 20% fast, 50% pre-charge
// - four-bit pre and term codes, 128 mA steps
// - pre-charge/termination register resets to 0x11
// - six-bit voltage code, 3.504 V plus 16 mV
// - charge voltage register resets to 0xB2
// - bit 1 selects 2.8 V or 3.0 V exit
// - bit 0 selects 100 mV or 300 mV recharge
// - all bits read back last written or default
// - slave address 0x6B, registers 0 to 7 accessible
module charge_current_voltage_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output var charge_regs_pkg::charge_settings_t settings_o
);

	// ----------------------------------------
	// pin synchronisers and glitch filter
	// ----------------------------------------
	logic [1:0] pin_meta;   // first stage, read only by the second
	logic [1:0] pin_s2;     // second stage
	logic [1:0] pin_s3;     // third stage
	logic [1:0] pin_filt;   // accepted level, bit 1 = scl, bit 0 = sda
	logic [1:0] pin_prev;   // accepted level one cycle ago
	logic [1:0] agree;      // second and third stage match

	assign agree = ~(pin_s2 ^ pin_s3);

	// the three stages cost about four cycles of delay on every pin edge; with
	// a bus phase of many system clocks this is harmless, and it keeps the first
	// stage's possibly unsettled output away from everything but the second stage
	// both lines reset to the idle high level so release never shows a false edge
	// a level is accepted only once two stages agree, so a one-cycle spike is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta <= 2'h3;
			pin_s2 <= 2'h3;
			pin_s3 <= 2'h3;
			pin_filt <= 2'h3;
			pin_prev <= 2'h3;
		end else begin
			pin_meta <= {scl_i, sda_i};
			pin_s2 <= pin_meta;
			pin_s3 <= pin_s2;
			pin_filt <= (agree & pin_s3) | (~agree & pin_filt);
			pin_prev <= pin_filt;
		end
	end

	// edges are taken from the filtered levels, one cycle apart
	// bus events seen on the filtered lines
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_now;

	assign sda_now = pin_filt[0];
	assign scl_rise = pin_filt[1] & ~pin_prev[1];
	assign scl_fall = ~pin_filt[1] & pin_prev[1];
	// start and stop need scl high in both samples, so they never coincide with an scl edge
	assign bus_start = pin_filt[1] & pin_prev[1] & pin_prev[0] & ~pin_filt[0];
	assign bus_stop = pin_filt[1] & pin_prev[1] & ~pin_prev[0] & pin_filt[0];

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] charge_current_register;         // fast charge code, cold select, force
	logic [7:0] precharge_termination_register;  // pre-charge and termination codes
	logic [7:0] charge_voltage_register;         // voltage code, exit and recharge selects

	// read multiplexer; offsets without storage read as zero
	function automatic logic [7:0] reg_read(input logic [7:0] ofs);
		logic [7:0] val;
		val = 8'h00;
		unique case (ofs)
			`CHARGE_CURRENT_OFS: val = charge_current_register;
			`PRECHARGE_TERM_OFS: val = precharge_termination_register;
			`CHARGE_VOLTAGE_OFS: val = charge_voltage_register;
			default: val = 8'h00;
		endcase
		return val;
	endfunction : reg_read

	// ----------------------------------------
	// serial slave sequencer
	// ----------------------------------------
	charge_regs_pkg::serial_state_t state;  // protocol phase
	logic [7:0] shreg;      // receive shift register
	logic [3:0] bit_cnt;    // bits taken in the current byte
	logic [7:0] ptr;        // register pointer, auto-increments
	logic [7:0] tx_byte;    // byte being returned to the host
	logic read_dir;         // address byte asked for a read
	logic host_nack;        // host declined another read byte
	logic wr_strobe;        // one-cycle write of wr_data into ptr
	logic [7:0] wr_data;    // byte to be stored

	// ----------------------------------------
	// read data select
	// ----------------------------------------
	// byte at the pointer, loaded into tx_byte when a read byte starts;
	// a named net also lets its top bit drive the first data bit directly
	logic [7:0] rd_byte;
	assign rd_byte = reg_read(ptr);

	// the sequencer works only on filtered pin events, never on raw pins
	// limitation: scl is input only, there is no clock stretching, so the byte
	// for a read must be ready at the falling edge that ends the acknowledge
	// a frame cut by a start or stop in mid-byte simply restarts or idles
	// receive side: sample sda on each rising scl
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shreg <= 8'h00;
			host_nack <= 1'b1;
		end else if (scl_rise) begin
			shreg <= {shreg[6:0], sda_now};
			if (state == charge_regs_pkg::st_rd_ack) begin
				host_nack <= sda_now;
			end
		end
	end

	// protocol phases; sda only changes on falling scl so it is stable while scl is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= charge_regs_pkg::st_idle;
			bit_cnt <= 4'h0;
			ptr <= 8'h00;
			tx_byte <= 8'h00;
			read_dir <= 1'b0;
			sda_oe_o <= 1'b0;
			sda_o <= 1'b0;
			wr_strobe <= 1'b0;
			wr_data <= 8'h00;
		end else begin
			wr_strobe <= 1'b0;
			sda_o <= 1'b0;  // open drain: the line is only ever pulled low
			if (bus_start) begin
				// a repeated start keeps the pointer for a following read
				state <= charge_regs_pkg::st_addr;
				bit_cnt <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (bus_stop) begin
				state <= charge_regs_pkg::st_idle;
				sda_oe_o <= 1'b0;
			end else if (scl_rise) begin
				bit_cnt <= bit_cnt + 4'h1;
			end else if (scl_fall) begin
				unique case (state)
					charge_regs_pkg::st_idle: begin
						sda_oe_o <= 1'b0;
					end
					charge_regs_pkg::st_addr: begin
						if (bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							// only our own address is acknowledged
							if (shreg[7:1] == `SLAVE_ADDR) begin
								read_dir <= shreg[0];
								sda_oe_o <= 1'b1;
								state <= charge_regs_pkg::st_addr_ack;
							end else begin
								state <= charge_regs_pkg::st_idle;
							end
						end
					end
					charge_regs_pkg::st_addr_ack: begin
						bit_cnt <= 4'h0;
						if (read_dir) begin
							tx_byte <= rd_byte;
							sda_oe_o <= ~rd_byte[7];
							state <= charge_regs_pkg::st_rd;
						end else begin
							sda_oe_o <= 1'b0;
							state <= charge_regs_pkg::st_ptr;
						end
					end
					charge_regs_pkg::st_ptr: begin
						if (bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							ptr <= shreg;
							sda_oe_o <= 1'b1;
							state <= charge_regs_pkg::st_ptr_ack;
						end
					end
					charge_regs_pkg::st_ptr_ack, charge_regs_pkg::st_wr_ack: begin
						bit_cnt <= 4'h0;
						sda_oe_o <= 1'b0;
						state <= charge_regs_pkg::st_wr;
					end
					charge_regs_pkg::st_wr: begin
						if (bit_cnt == 4'h8) begin
							// every byte is acknowledged; only mapped offsets store it
							bit_cnt <= 4'h0;
							wr_data <= shreg;
							wr_strobe <= 1'b1;
							sda_oe_o <= 1'b1;
							state <= charge_regs_pkg::st_wr_ack;
						end
					end
					charge_regs_pkg::st_rd: begin
						if (bit_cnt == 4'h8) begin
							// let go of the line for the host's acknowledge
							sda_oe_o <= 1'b0;
							ptr <= ptr + 8'h01;
							state <= charge_regs_pkg::st_rd_ack;
						end else begin
							sda_oe_o <= ~tx_byte[3'h7 - bit_cnt[2:0]];
						end
					end
					charge_regs_pkg::st_rd_ack: begin
						bit_cnt <= 4'h0;
						if (host_nack) begin
							sda_oe_o <= 1'b0;
							state <= charge_regs_pkg::st_idle;
						end else begin
							tx_byte <= rd_byte;
							sda_oe_o <= ~rd_byte[7];
							state <= charge_regs_pkg::st_rd;
						end
					end
				endcase
			end else if (wr_strobe) begin
				// advance after the store so a burst fills successive registers
				ptr <= ptr + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// a write to an unmapped offset is acknowledged and then dropped, so a burst
	// that starts below offset 2 still lands its later bytes in place
	// whole bytes are stored; offsets 0 to 7 take writes, only three hold state here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			charge_current_register <= `CHARGE_CURRENT_RST;
			precharge_termination_register <= `PRECHARGE_TERM_RST;
			charge_voltage_register <= `CHARGE_VOLTAGE_RST;
		end else if (wr_strobe && ptr <= `ACCESS_LAST) begin
			unique case (ptr)
				`CHARGE_CURRENT_OFS: charge_current_register <= wr_data;
				`PRECHARGE_TERM_OFS: precharge_termination_register <= wr_data;
				`CHARGE_VOLTAGE_OFS: charge_voltage_register <= wr_data;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	logic [5:0] fast_charge_current_code;
	logic [3:0] precharge_current_code;
	logic [3:0] termination_current_code;
	logic [5:0] charge_voltage_code;
	logic reduced_current_force;
	logic [12:0] fast_full_ma;      // programmed fast charge current
	logic [12:0] precharge_setting; // programmed pre-charge current

	// field slices; positions live in the configuration header
	assign fast_charge_current_code = charge_current_register[`FCC_MSB:`FCC_LSB];
	assign reduced_current_force = charge_current_register[`FORCE_BIT];
	assign precharge_current_code = precharge_termination_register[`PRE_MSB:`PRE_LSB];
	assign termination_current_code = precharge_termination_register[`TERM_MSB:`TERM_LSB];
	assign charge_voltage_code = charge_voltage_register[`CV_MSB:`CV_LSB];
	// codes above the 3008 mA point are the host's to avoid; they decode linearly
	assign fast_full_ma = `FCC_BASE_MA + 13'(fast_charge_current_code) * `FCC_STEP_MA;
	assign precharge_setting = `PRE_BASE_MA + 13'(precharge_current_code) * `PRE_STEP_MA;

	// the settings flops cost one cycle but keep every output straight from a
	// flip-flop, so the charge control logic never sees decode glitches
	// registered settings; they follow a stored byte one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settings_o <= '0;
		end else begin
			if (reduced_current_force) begin
				// integer divide truncates, less than one mA under an exact fifth
				settings_o.fast_charge_ma <= 13'(fast_full_ma / `REDUCED_FCC_DIV);
				settings_o.precharge_ma <= precharge_setting >> 1;
			end else begin
				settings_o.fast_charge_ma <= fast_full_ma;
				settings_o.precharge_ma <= precharge_setting;
			end
			settings_o.termination_ma <= `PRE_BASE_MA + 13'(termination_current_code) * `PRE_STEP_MA;
			settings_o.charge_voltage_mv <= `CV_BASE_MV + 13'(charge_voltage_code) * `CV_STEP_MV;
			settings_o.precharge_exit_mv <= charge_voltage_register[`EXIT_BIT] ? `EXIT_HIGH_MV :
				`EXIT_LOW_MV;
			settings_o.recharge_offset_mv <= charge_voltage_register[`RECHG_BIT] ? `RECHG_HIGH_MV :
				`RECHG_LOW_MV;
			settings_o.cold_threshold_sel <= charge_current_register[`COLD_SEL_BIT];
			settings_o.reduced_current_force <= reduced_current_force;
		end
	end

endmodule : charge_current_voltage_regs
`default_nettype wire

// >>> src/charge_regs_cfg.svh
// constants for the charge current and voltage register bank
`ifndef CHARGE_REGS_CFG_SVH
`define CHARGE_REGS_CFG_SVH

// ----------------------------------------
// serial port
// ----------------------------------------
`define SLAVE_ADDR 7'h6B
`define ACCESS_LAST 8'h07

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define CHARGE_CURRENT_OFS 8'h02
`define PRECHARGE_TERM_OFS 8'h03
`define CHARGE_VOLTAGE_OFS 8'h04
`define CHARGE_CURRENT_RST 8'h20
`define PRECHARGE_TERM_RST 8'h11
`define CHARGE_VOLTAGE_RST 8'hB2

// ----------------------------------------
// field positions
// ----------------------------------------
`define FCC_MSB 7
`define FCC_LSB 2
`define COLD_SEL_BIT 1
`define FORCE_BIT 0
`define PRE_MSB 7
`define PRE_LSB 4
`define TERM_MSB 3
`define TERM_LSB 0
`define CV_MSB 7
`define CV_LSB 2
`define EXIT_BIT 1
`define RECHG_BIT 0

// ----------------------------------------
// decode scales, milliamps and millivolts
// ----------------------------------------
`define FCC_BASE_MA 13'h0200
`define FCC_STEP_MA 13'h0040
`define PRE_BASE_MA 13'h0080
`define PRE_STEP_MA 13'h0080
`define CV_BASE_MV 13'h0DB0
`define CV_STEP_MV 13'h0010
`define EXIT_LOW_MV 13'h0AF0
`define EXIT_HIGH_MV 13'h0BB8
`define RECHG_LOW_MV 13'h0064
`define RECHG_HIGH_MV 13'h012C
`define REDUCED_FCC_DIV 13'h0005

`endif

// >>> src/charge_regs_pkg.sv
// types shared by the charge current and voltage register bank
`default_nettype none
package charge_regs_pkg;

	// serial slave sequencer states
	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_addr_ack,
		st_ptr,
		st_ptr_ack,
		st_wr,
		st_wr_ack,
		st_rd,
		st_rd_ack
	} serial_state_t;

	// decoded settings handed to the charge control logic
	typedef struct packed {
		logic [12:0] fast_charge_ma;      // applied fast charge current
		logic [12:0] precharge_ma;        // applied pre-charge current
		logic [12:0] termination_ma;      // termination current
		logic [12:0] charge_voltage_mv;   // regulation voltage
		logic [12:0] precharge_exit_mv;   // pre-charge to fast charge threshold
		logic [12:0] recharge_offset_mv;  // drop below regulation before recharge
		logic cold_threshold_sel;         // 0: ~76 %, 1: ~79 % of regulator output
		logic reduced_current_force;      // reduced current mode active
	} charge_settings_t;

endpackage : charge_regs_pkg
`default_nettype wire

// >>> tb/charge_current_voltage_regs_assertions.sv
// port checks for the charge register bank
`timescale 1ns/1ns
`default_nettype none
module charge_current_voltage_regs_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire charge_regs_pkg::charge_settings_t settings_o
);
	// one domain, so clock and reset are named once
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_sda_low_only: assert property (sda_o == 1'b0) else $error("data pin driven high");
	a_pin_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
	// second edge after release must show decoded defaults
	a_reset_defaults: assert property ($past(rst_i) |=> settings_o == {13'h0400, 13'h0100, 13'h0100, 13'h1070,
		13'h0BB8, 13'h0064, 2'h0}) else $error("defaults wrong");
	// settings still hold the reset zero at the first edge after release
	a_fast_step: assert property (!$past(rst_i) && !settings_o.reduced_current_force
		|-> settings_o.fast_charge_ma >= 13'h0200 && settings_o.fast_charge_ma[5:0] == 6'h00)
		else $error("fast current off grid");
	a_reduced_scale: assert property (settings_o.reduced_current_force |-> settings_o.precharge_ma[5:0] == 6'h00
		&& settings_o.precharge_ma <= 13'h0400 && settings_o.fast_charge_ma <= 13'h038C) else $error("reduced off");
	a_term_step: assert property (!$past(rst_i) |-> settings_o.termination_ma[6:0] == 7'h00
		&& settings_o.termination_ma >= 13'h0080 && settings_o.termination_ma <= 13'h0800)
		else $error("termination off grid");
	a_voltage_step: assert property (!$past(rst_i) |-> settings_o.charge_voltage_mv[3:0] == 4'h0
		&& settings_o.charge_voltage_mv >= 13'h0DB0 && settings_o.charge_voltage_mv <= 13'h11A0) else $error("voltage");
	a_exit_select: assert property (!$past(rst_i)
		|-> settings_o.precharge_exit_mv inside {13'h0AF0, 13'h0BB8}) else $error("exit");
	a_recharge_select: assert property (!$past(rst_i)
		|-> settings_o.recharge_offset_mv inside {13'h0064, 13'h012C}) else $error("rch");
	// a store only follows a falling clock, never the idle bus
	a_store_scl_low: assert property (!$stable(settings_o) && !$past(rst_i, 2) |-> !scl_i) else $error("late");
endmodule : charge_current_voltage_regs_assertions
`default_nettype wire

// >>> tb/charge_current_voltage_regs_test.sv
// self-checking bench for the charge register bank
`timescale 1ns/1ns
`default_nettype none
module charge_current_voltage_regs_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	wire logic scl;
	wire logic host_oe;
	logic sda_o;
	logic sda_oe_o;
	charge_regs_pkg::charge_settings_t settings_o;
	wire logic sda = !(sda_oe_o || host_oe); // pulled up unless someone pulls low
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] rb;
	logic ack;
	charge_current_voltage_regs charge_current_voltage_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .settings_o(settings_o));
	i2c_host_model i2c_host_model_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
	initial forever #50 clk_i = ~clk_i;
	// hang guard, well above the whole run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (bad_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// address the device for writing and set the pointer
	task automatic head(input logic [7:0] p);
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer(8'hD6, 1'b1, rb, ack);
		chk(13'(ack), 13'h0001);
		i2c_host_model_inst.xfer(p, 1'b1, rb, ack);
	endtask : head
	task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n);
		head(p);
		for (int i = 0; i < n; i++) i2c_host_model_inst.xfer(d[23-8*i -: 8], 1'b1, rb, ack);
		i2c_host_model_inst.stop();
	endtask : wr
	// burst read, the last byte refused by the host
	task automatic rd(input logic [7:0] p, input logic [23:0] e, input int n);
		head(p);
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer(8'hD7, 1'b1, rb, ack);
		for (int i = 0; i < n; i++) begin
			i2c_host_model_inst.xfer(8'hFF, i == n - 1, rb, ack);
			chk(13'(rb), 13'(e[23-8*i -: 8]));
		end
		i2c_host_model_inst.stop();
	endtask : rd
	task automatic chks(input logic [12:0] f, pr, t, v, x, r, input logic c, fo);
		chk(settings_o.fast_charge_ma, f);
		chk(settings_o.precharge_ma, pr);
		chk(settings_o.termination_ma, t);
		chk(settings_o.charge_voltage_mv, v);
		chk(settings_o.precharge_exit_mv, x);
		chk(settings_o.recharge_offset_mv, r);
		chk(13'(settings_o.cold_threshold_sel), 13'(c));
		chk(13'(settings_o.reduced_current_force), 13'(fo));
	endtask : chks
	// defaults: 1024 mA, 256 mA, 256 mA, 4208 mV, 3.0 V exit, 100 mV
	task automatic t_reset();
		chks(13'h0400, 13'h0100, 13'h0100, 13'h1070, 13'h0BB8, 13'h0064, 1'b0, 1'b0);
		rd(8'h02, 24'h20_11B2, 3);
	endtask : t_reset
	// top legal fast, pre-charge and voltage codes, lowest termination: 3008 mA, 2048 mA, 128 mA, 4400 mV, 2.8 V, 300 mV
	task automatic t_write();
		wr(8'h02, 24'h9E_F0E1, 3);
		chks(13'h0BC0, 13'h0800, 13'h0080, 13'h1130, 13'h0AF0, 13'h012C, 1'b1, 1'b0);
		rd(8'h02, 24'h9E_F0E1, 3);
	endtask : t_write
	// reduced mode: 1024/5 fast, 128/2 pre-charge, zero voltage code
	task automatic t_force();
		wr(8'h02, 24'h21_0000, 3);
		chks(13'h00CC, 13'h0040, 13'h0080, 13'h0DB0, 13'h0AF0, 13'h0064, 1'b0, 1'b1);
	endtask : t_force
	// another slave address gets no acknowledge and changes nothing
	task automatic t_other_addr();
		i2c_host_model_inst.start();
		i2c_host_model_inst.xfer(8'hD4, 1'b1, rb, ack);
		chk(13'(ack), 13'h0000);
		i2c_host_model_inst.stop();
		rd(8'h02, 24'h21_0000, 3);
	endtask : t_other_addr
	// an unmapped offset takes a byte and drops it, reads zero, and the pointer still steps
	task automatic t_unmapped();
		wr(8'h01, 24'h55_2042, 3);
		chks(13'h0400, 13'h0280, 13'h0180, 13'h0DB0, 13'h0AF0, 13'h0064, 1'b0, 1'b0);
		rd(8'h01, 24'h00_2042, 3);
	endtask : t_unmapped
	initial begin
		repeat (6) @(posedge clk_i);
		#1 rst_i = 1'b0;
		repeat (6) @(posedge clk_i);
		#1;
		t_reset();
		t_write();
		t_force();
		t_other_addr();
		t_unmapped();
		complete_run();
	end
endmodule : charge_current_voltage_regs_test
bind charge_current_voltage_regs charge_current_voltage_regs_assertions charge_current_voltage_regs_assertions_inst (
	.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.settings_o(settings_o));
`default_nettype wire

// >>> tb/i2c_host_model.sv
// behavioural serial host with open-drain data drive
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// bus idles high on both lines
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// a third of a bus bit period, well above the pin filter delay
	task automatic hp();
		repeat (40) @(posedge clk_i);
		#1;
	endtask : hp
	// start, also a repeated start from a low clock
	task automatic start();
		sda_oe_o = 1'b0;
		hp();
		scl_o = 1'b1;
		hp();
		sda_oe_o = 1'b1;
		hp();
		scl_o = 1'b0;
		hp();
	endtask : start
	task automatic stop();
		sda_oe_o = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		sda_oe_o = 1'b0;
		hp();
	endtask : stop
	// data changes only while the clock is low
	task automatic bit_x(input logic b, output logic r);
		sda_oe_o = !b;
		hp();
		scl_o = 1'b1;
		hp();
		r = sda_i;
		scl_o = 1'b0;
		hp();
	endtask : bit_x
	// msb first, then the acknowledge clock
	task automatic xfer(input logic [7:0] w, input logic last_b, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
		bit_x(last_b, a);
		ack = !a;
	endtask : xfer
endmodule : i2c_host_model
`default_nettype wire
